// ==== design/pced_pkg.sv ====
// Package of register map, field layout and reset values for the pin change edge detector
package pced_pkg;
    // Register byte offsets
    localparam logic [5:0] OFF_A_RISE  = 6'h00;  // Port A rise arm
    localparam logic [5:0] OFF_A_FALL  = 6'h04;  // Port A fall arm
    localparam logic [5:0] OFF_A_FLAG  = 6'h08;  // Port A change flags
    localparam logic [5:0] OFF_B_RISE  = 6'h0c;  // Port B rise arm
    localparam logic [5:0] OFF_B_FALL  = 6'h10;  // Port B fall arm
    localparam logic [5:0] OFF_B_FLAG  = 6'h14;  // Port B change flags
    localparam logic [5:0] OFF_C_RISE  = 6'h18;  // Port C rise arm
    localparam logic [5:0] OFF_C_FALL  = 6'h1c;  // Port C fall arm
    localparam logic [5:0] OFF_C_FLAG  = 6'h20;  // Port C change flags
    localparam logic [5:0] OFF_CTRL    = 6'h24;  // Interrupt enable
    localparam logic [5:0] OFF_IRQ_STS = 6'h28;  // Sticky event status, W1C
    localparam logic [5:0] OFF_IRQ_MSK = 6'h2c;  // Event mask
    // Implemented pin masks
    localparam logic [7:0] MASK_A      = 8'h3f;  // Port A pins 5..0
    localparam logic [7:0] MASK_B      = 8'hf0;  // Port B pins 7..4
    localparam logic [7:0] MASK_C_BIG  = 8'hff;  // Port C, large variant
    localparam logic [7:0] MASK_C_SML  = 8'h3f;  // Port C, small variant
    // Field positions
    localparam int         CTRL_IE_BIT = 0;      // Pin change irq enable
    localparam int         STS_A_BIT   = 0;      // Port A event
    localparam int         STS_B_BIT   = 1;      // Port B event
    localparam int         STS_C_BIT   = 2;      // Port C event
    // Reset values
    localparam logic [7:0] RST_REG     = 8'h00;  // All registers clear
    localparam logic [2:0] STS_MASK    = 3'h7;   // Implemented status bits
    // Pin groups
    localparam int         NUM_PORTS   = 3;      // Ports A, B, C
endpackage

// ==== design/pced_port_if.sv ====
// Interface between the top and one port's edge detector
`timescale 1ns/1ns
interface pced_port_if;
    logic [7:0] rise_arm;   // Rising edge enables
    logic [7:0] fall_arm;   // Falling edge enables
    logic [7:0] clr_mask;   // Flags software clears this cycle
    logic [7:0] flags;      // Current flag state
    logic       event_hit;  // Pulse: some flag newly set
    modport det (input rise_arm, input fall_arm, input clr_mask, output flags, output event_hit);
    modport ctl (output rise_arm, output fall_arm, output clr_mask, input flags, input event_hit);
endinterface

// ==== design/pced_sync.sv ====
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pced_sync #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         resetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] stage1_reg;  // Read only by second stage

    // Two flops in series
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            stage1_reg <= '0;
            sync_out   <= '0;
        end else if (clk_en) begin
            stage1_reg <= async_in;
            sync_out   <= stage1_reg;
        end
    end
endmodule

// ==== design/pced_edge_det.sv ====
// Per-port edge detector holding the sticky change flags
`timescale 1ns/1ns
module pced_edge_det #(
    parameter logic [7:0] PIN_MASK = 8'hff
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic [7:0] pin_sync,
    pced_port_if.det        port
);
    logic [7:0] prev_reg;  // Pin state one cycle ago
    logic [7:0] hit;       // Armed edges this cycle

    // Edge qualified by arm bits and implemented pins
    always_comb begin
        hit = (((pin_sync & ~prev_reg) & port.rise_arm)
             | ((~pin_sync & prev_reg) & port.fall_arm))
             & PIN_MASK;
    end

    // Previous pin sample
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prev_reg <= '0;
        end else if (clk_en) begin
            prev_reg <= pin_sync;
        end
    end

    // Flags: set beats software clear
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            port.flags <= pced_pkg::RST_REG;
        end else if (clk_en) begin
            port.flags <= ((port.flags & ~port.clr_mask) | hit) & PIN_MASK;
        end
    end

    // Newly set event pulse
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            port.event_hit <= 1'b0;
        end else if (clk_en) begin
            port.event_hit <= |hit;
        end
    end
endmodule

// ==== design/pced_top.sv ====
// Top of the pin change edge detector with Avalon-MM register slave
//
// Implementation choices: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns

// Overview of operation
// - Armed rising edge sets pin flag
// - Armed falling edge sets pin flag
// - Software writes zero to clear; set wins
// - All flags clear on every reset
// - Unimplemented bits read back as zero
module pced_top #(
    parameter bit BIG_VARIANT = 1'b1
) (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       clk_en,
    input  wire logic [5:0] avs_address,
    input  wire logic       avs_read,
    input  wire logic       avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0] avs_byteenable,
    output logic     [31:0] avs_readdata,
    output logic            avs_waitrequest,
    input  wire logic [7:0] port_a_pin,
    input  wire logic [7:0] port_b_pin,
    input  wire logic [7:0] port_c_pin,
    output logic            pin_change_irq,
    output logic            event_irq
);
    localparam logic [7:0] MASK_C = BIG_VARIANT ? pced_pkg::MASK_C_BIG : pced_pkg::MASK_C_SML;

    logic [7:0] a_sync;          // Synchronised port A
    logic [7:0] b_sync;          // Synchronised port B
    logic [7:0] c_sync;          // Synchronised port C
    logic [7:0] a_rise_reg;      // Port A rise arm
    logic [7:0] a_fall_reg;      // Port A fall arm
    logic [7:0] b_rise_reg;      // Port B rise arm
    logic [7:0] b_fall_reg;      // Port B fall arm
    logic [7:0] c_rise_reg;      // Port C rise arm
    logic [7:0] c_fall_reg;      // Port C fall arm
    logic       irq_en_reg;      // Pin change irq enable
    logic [2:0] sts_reg;         // Sticky event status
    logic [2:0] msk_reg;         // Event mask
    logic       ack_reg;         // Access answered this cycle
    logic       wr_fire;         // Write takes effect
    logic       rd_fire;         // Read data loaded, one edge before the answer
    logic [7:0] wbyte;           // Low write byte
    logic       wlane;           // Low lane enabled

    pced_port_if pa ();
    pced_port_if pb ();
    pced_port_if pc ();

    // Input synchronisers
    pced_sync #(.W(8)) u_sync_a (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
                                 .async_in(port_a_pin), .sync_out(a_sync));
    pced_sync #(.W(8)) u_sync_b (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
                                 .async_in(port_b_pin), .sync_out(b_sync));
    pced_sync #(.W(8)) u_sync_c (.core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
                                 .async_in(port_c_pin), .sync_out(c_sync));

    // Edge detectors, one per port
    pced_edge_det #(.PIN_MASK(pced_pkg::MASK_A)) u_det_a (.core_clk(core_clk), .resetn(resetn),
                                 .clk_en(clk_en), .pin_sync(a_sync), .port(pa));
    pced_edge_det #(.PIN_MASK(pced_pkg::MASK_B)) u_det_b (.core_clk(core_clk), .resetn(resetn),
                                 .clk_en(clk_en), .pin_sync(b_sync), .port(pb));
    pced_edge_det #(.PIN_MASK(MASK_C)) u_det_c (.core_clk(core_clk), .resetn(resetn),
                                 .clk_en(clk_en), .pin_sync(c_sync), .port(pc));

    // Bus handshake: one wait cycle, answer on second edge
    assign wr_fire = clk_en && avs_write && !avs_read && ack_reg;
    // Read data loads as waitrequest drops, so it already stands at the answer edge
    assign rd_fire = clk_en && avs_read && !avs_write && !ack_reg;
    assign wbyte   = avs_writedata[7:0];
    assign wlane   = avs_byteenable[0];

    // Arm and clear controls to detectors
    assign pa.rise_arm = a_rise_reg;
    assign pa.fall_arm = a_fall_reg;
    assign pb.rise_arm = b_rise_reg;
    assign pb.fall_arm = b_fall_reg;
    assign pc.rise_arm = c_rise_reg;
    assign pc.fall_arm = c_fall_reg;

    // Clear mask: bits written as zero clear a flag
    function automatic logic [7:0] clr_of(input logic hit_addr, input logic [7:0] d);
        return (hit_addr && wr_fire && wlane) ? ~d : 8'h00;
    endfunction

    assign pa.clr_mask = clr_of(avs_address == pced_pkg::OFF_A_FLAG, wbyte);
    assign pb.clr_mask = clr_of(avs_address == pced_pkg::OFF_B_FLAG, wbyte);
    assign pc.clr_mask = clr_of(avs_address == pced_pkg::OFF_C_FLAG, wbyte);

    // Acknowledge toggles: wait one cycle, then answer
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ack_reg <= 1'b0;
        end else if (clk_en) begin
            ack_reg <= (avs_read ^ avs_write) && !ack_reg;
        end
    end

    // Waitrequest high unless answering next edge
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_waitrequest <= 1'b1;
        end else if (clk_en) begin
            avs_waitrequest <= !((avs_read ^ avs_write) && !ack_reg);
        end
    end

    // Arm registers, masked to implemented pins
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            a_rise_reg <= pced_pkg::RST_REG;
            a_fall_reg <= pced_pkg::RST_REG;
            b_rise_reg <= pced_pkg::RST_REG;
            b_fall_reg <= pced_pkg::RST_REG;
            c_rise_reg <= pced_pkg::RST_REG;
            c_fall_reg <= pced_pkg::RST_REG;
        end else if (wr_fire && wlane) begin
            if (avs_address == pced_pkg::OFF_A_RISE) begin
                a_rise_reg <= wbyte & pced_pkg::MASK_A;
            end else if (avs_address == pced_pkg::OFF_A_FALL) begin
                a_fall_reg <= wbyte & pced_pkg::MASK_A;
            end else if (avs_address == pced_pkg::OFF_B_RISE) begin
                b_rise_reg <= wbyte & pced_pkg::MASK_B;
            end else if (avs_address == pced_pkg::OFF_B_FALL) begin
                b_fall_reg <= wbyte & pced_pkg::MASK_B;
            end else if (avs_address == pced_pkg::OFF_C_RISE) begin
                c_rise_reg <= wbyte & MASK_C;
            end else if (avs_address == pced_pkg::OFF_C_FALL) begin
                c_fall_reg <= wbyte & MASK_C;
            end
        end
    end

    // Control and mask registers
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_en_reg <= 1'b0;
            msk_reg    <= '0;
        end else if (wr_fire && wlane) begin
            if (avs_address == pced_pkg::OFF_CTRL) begin
                irq_en_reg <= wbyte[pced_pkg::CTRL_IE_BIT];
            end else if (avs_address == pced_pkg::OFF_IRQ_MSK) begin
                msk_reg <= wbyte[2:0] & pced_pkg::STS_MASK;
            end
        end
    end

    // Sticky event status: write one clears, new event wins
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sts_reg <= '0;
        end else if (clk_en) begin
            sts_reg <= (sts_reg & ~((wr_fire && wlane && avs_address == pced_pkg::OFF_IRQ_STS)
                                    ? wbyte[2:0] : 3'h0))
                     | {pc.event_hit, pb.event_hit, pa.event_hit};
        end
    end

    // Read data mux; unmapped reads zero
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            avs_readdata <= '0;
        end else if (rd_fire) begin
            if (avs_address == pced_pkg::OFF_A_RISE) begin
                avs_readdata <= {24'h0, a_rise_reg};
            end else if (avs_address == pced_pkg::OFF_A_FALL) begin
                avs_readdata <= {24'h0, a_fall_reg};
            end else if (avs_address == pced_pkg::OFF_A_FLAG) begin
                avs_readdata <= {24'h0, pa.flags};
            end else if (avs_address == pced_pkg::OFF_B_RISE) begin
                avs_readdata <= {24'h0, b_rise_reg};
            end else if (avs_address == pced_pkg::OFF_B_FALL) begin
                avs_readdata <= {24'h0, b_fall_reg};
            end else if (avs_address == pced_pkg::OFF_B_FLAG) begin
                avs_readdata <= {24'h0, pb.flags};
            end else if (avs_address == pced_pkg::OFF_C_RISE) begin
                avs_readdata <= {24'h0, c_rise_reg};
            end else if (avs_address == pced_pkg::OFF_C_FALL) begin
                avs_readdata <= {24'h0, c_fall_reg};
            end else if (avs_address == pced_pkg::OFF_C_FLAG) begin
                avs_readdata <= {24'h0, pc.flags};
            end else if (avs_address == pced_pkg::OFF_CTRL) begin
                avs_readdata <= {31'h0, irq_en_reg};
            end else if (avs_address == pced_pkg::OFF_IRQ_STS) begin
                avs_readdata <= {29'h0, sts_reg};
            end else if (avs_address == pced_pkg::OFF_IRQ_MSK) begin
                avs_readdata <= {29'h0, msk_reg};
            end else begin
                avs_readdata <= '0;
            end
        end
    end

    // Combined pin change request, gated by enable
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            pin_change_irq <= 1'b0;
        end else if (clk_en) begin
            pin_change_irq <= irq_en_reg && |{pa.flags, pb.flags, pc.flags};
        end
    end

    // Masked sticky status interrupt
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            event_irq <= 1'b0;
        end else if (clk_en) begin
            event_irq <= |(sts_reg & msk_reg);
        end
    end
endmodule

// ==== verif/pced_chk.sv ====
// Checker of the pin change edge detector at its top ports
`timescale 1ns/1ns
module pced_chk #(
    parameter bit BIG_VARIANT = 1'b1
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        clk_en,
    input wire logic [5:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic [7:0]  port_a_pin,
    input wire logic [7:0]  port_b_pin,
    input wire logic [7:0]  port_c_pin,
    input wire logic        pin_change_irq,
    input wire logic        event_irq
);
    logic       acc_wr;     // Write taken at this edge
    logic       ie_sh;      // Copy of irq enable
    logic [7:0] c_rise_sh;  // Copy of port C rise arm
    logic [7:0] c_fall_sh;  // Copy of port C fall arm
    logic       clr_sh;     // Flag or enable write just taken
    logic       rd_done;    // Read answered at the last edge
    logic [5:0] rd_off;     // Offset of that read
    assign acc_wr = avs_write && !avs_waitrequest && avs_byteenable[0] && clk_en;
    // Readable bits at each offset
    function automatic logic [7:0] rd_mask(logic [5:0] a);
        case (a)
            pced_pkg::OFF_A_RISE, pced_pkg::OFF_A_FALL, pced_pkg::OFF_A_FLAG: return pced_pkg::MASK_A;
            pced_pkg::OFF_B_RISE, pced_pkg::OFF_B_FALL, pced_pkg::OFF_B_FLAG: return pced_pkg::MASK_B;
            pced_pkg::OFF_C_RISE, pced_pkg::OFF_C_FALL, pced_pkg::OFF_C_FLAG:
                return BIG_VARIANT ? pced_pkg::MASK_C_BIG : pced_pkg::MASK_C_SML;
            pced_pkg::OFF_CTRL: return 8'h01;
            pced_pkg::OFF_IRQ_STS, pced_pkg::OFF_IRQ_MSK: return {5'h00, pced_pkg::STS_MASK};
            default: return 8'h00;
        endcase
    endfunction
    // Track the software state the properties lean on
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ie_sh     <= 1'b0;
            c_rise_sh <= 8'h00;
            c_fall_sh <= 8'h00;
            clr_sh    <= 1'b0;
            rd_done   <= 1'b0;
            rd_off    <= 6'h00;
        end else begin
            if (acc_wr && avs_address == pced_pkg::OFF_CTRL) ie_sh <= avs_writedata[0];
            if (acc_wr && avs_address == pced_pkg::OFF_C_RISE) c_rise_sh <= avs_writedata[7:0];
            if (acc_wr && avs_address == pced_pkg::OFF_C_FALL) c_fall_sh <= avs_writedata[7:0];
            clr_sh  <= acc_wr && (avs_address == pced_pkg::OFF_A_FLAG || avs_address == pced_pkg::OFF_B_FLAG ||
                       avs_address == pced_pkg::OFF_C_FLAG || avs_address == pced_pkg::OFF_CTRL);
            rd_done <= avs_read && !avs_waitrequest && clk_en;
            if (avs_read && !avs_waitrequest) rd_off <= avs_address;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    rise_sets_a: assert property (ie_sh && |(port_c_pin & ~$past(port_c_pin) & c_rise_sh) |-> ##[1:6] pin_change_irq)
        else $error("armed rising edge raised no pin change irq");
    fall_sets_a: assert property (ie_sh && |(~port_c_pin & $past(port_c_pin) & c_fall_sh) |-> ##[1:6] pin_change_irq)
        else $error("armed falling edge raised no pin change irq");
    irq_drop_a: assert property ($fell(pin_change_irq) |-> clr_sh || $past(clr_sh) || $past(clr_sh, 2))
        else $error("pin change irq dropped without a software write");
    bus_ack_a: assert property ((avs_read ^ avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered after one wait cycle");
    reset_clear_a: assert property (disable iff (1'b0) !resetn && clk_en |=>
        !pin_change_irq && !event_irq && avs_waitrequest && avs_readdata == 32'h0)
        else $error("outputs not cleared by reset");
    unused_zero_a: assert property (rd_done |-> (avs_readdata & ~{24'h0, rd_mask(rd_off)}) == 32'h0)
        else $error("unimplemented bit read back as one");
    irq_gate_a: assert property (!ie_sh && !$past(ie_sh) |-> !pin_change_irq)
        else $error("pin change irq high while disabled");
    cover property (acc_wr && avs_address == pced_pkg::OFF_C_FLAG);
    cover property (rd_done && avs_readdata != 32'h0);
    cover property ($rose(event_irq));
endmodule

bind pced_top pced_chk #(.BIG_VARIANT(BIG_VARIANT)) pced_chk_i (
    .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .port_a_pin(port_a_pin),
    .port_b_pin(port_b_pin), .port_c_pin(port_c_pin), .pin_change_irq(pin_change_irq), .event_irq(event_irq));

// ==== verif/pced_pin_model.sv ====
// Model of the external drivers on the three monitored ports
`timescale 1ns/1ns
module pced_pin_model (
    input  wire logic [7:0] want_a,
    input  wire logic [7:0] want_b,
    input  wire logic [7:0] want_c,
    input  wire logic       core_clk,
    output logic      [7:0] pin_a,
    output logic      [7:0] pin_b,
    output logic      [7:0] pin_c
);
    // Pins start low and follow requests one edge late
    initial begin
        pin_a = 8'h00;
        pin_b = 8'h00;
        pin_c = 8'h00;
    end
    always @(posedge core_clk) begin
        pin_a <= want_a;
        pin_b <= want_b;
        pin_c <= want_c;
    end
endmodule

// ==== verif/pced_tb_top.sv ====
// Self-checking testbench of the pin change edge detector
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin bad_count++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module pced_tb_top;
    logic        core_clk = 1'b0;  // 125 MHz clock
    logic        resetn = 1'b0;    // Synchronous reset
    logic [5:0]  avs_address = 6'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [7:0]  want [3] = '{8'h00, 8'h00, 8'h00};  // Requested pin levels
    logic [7:0]  pin_a, pin_b, pin_c;
    logic        pin_change_irq, event_irq;
    logic [7:0]  arm_r [3], arm_f [3], flg [3];      // Expected registers
    logic        ie_m;
    logic [2:0]  sts_m, msk_m;
    logic [15:0] lfsr = 16'h9d65;                    // Seed 40293
    int          bad_count = 0, n_tests = 0;
    always #4 core_clk = ~core_clk;
    pced_pin_model pced_pin_model_i (.want_a(want[0]), .want_b(want[1]), .want_c(want[2]),
        .core_clk(core_clk), .pin_a(pin_a), .pin_b(pin_b), .pin_c(pin_c));
    pced_top #(.BIG_VARIANT(1'b1)) pced_top_i (.core_clk(core_clk), .resetn(resetn), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_pin(pin_a), .port_b_pin(pin_b), .port_c_pin(pin_c), .pin_change_irq(pin_change_irq),
        .event_irq(event_irq));
    // Eight shifts per byte so successive values are unrelated
    function automatic logic [7:0] rnd8();
        for (int i = 0; i < 8; i++) lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        return lfsr[7:0];
    endfunction
    function automatic logic [7:0] pmask(int p);
        return p == 0 ? pced_pkg::MASK_A : p == 1 ? pced_pkg::MASK_B : pced_pkg::MASK_C_BIG;
    endfunction
    // Expected read value; ports sit at twelve-byte strides
    function automatic logic [7:0] exp_rd(logic [5:0] a);
        int p = a / 12;
        int k = (a % 12) / 4;
        if (a == pced_pkg::OFF_CTRL) return {7'h00, ie_m};
        if (a == pced_pkg::OFF_IRQ_STS) return {5'h00, sts_m};
        if (a == pced_pkg::OFF_IRQ_MSK) return {5'h00, msk_m};
        if (a > pced_pkg::OFF_IRQ_MSK) return 8'h00;
        return k == 0 ? arm_r[p] : k == 1 ? arm_f[p] : flg[p];
    endfunction
    task automatic mdl_clr();
        for (int i = 0; i < 3; i++) begin
            arm_r[i] = 8'h00;
            arm_f[i] = 8'h00;
            flg[i] = 8'h00;
        end
        {ie_m, sts_m, msk_m} = 7'h00;
    endtask
    task automatic mdl_wr(input logic [5:0] a, input logic [7:0] d);
        int p = a / 12;
        int k = (a % 12) / 4;
        if (a == pced_pkg::OFF_CTRL) ie_m = d[0];
        else if (a == pced_pkg::OFF_IRQ_STS) sts_m = sts_m & ~d[2:0];
        else if (a == pced_pkg::OFF_IRQ_MSK) msk_m = d[2:0];
        else if (a < pced_pkg::OFF_CTRL) begin
            if (k == 0) arm_r[p] = d & pmask(p);
            else if (k == 1) arm_f[p] = d & pmask(p);
            else flg[p] = flg[p] & d;
        end
    endtask
    // Avalon write: hold until waitrequest is sampled low
    task automatic bus_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= {24'h0, d};
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        mdl_wr(a, d);
    endtask
    // Avalon read, data taken at the edge waitrequest is sampled low
    task automatic chk_rd(input logic [5:0] a);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        `CHK("read data", {24'h0, exp_rd(a)}, avs_readdata)
        avs_read <= 1'b0;
    endtask
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well beyond the expected thousand or so cycles
    initial begin
        repeat (20000) @(posedge core_clk);
        bad_count++;
        test_done();
    end
    // Main sequence
    initial begin
        int p;
        logic [7:0] old_v, new_v, hit_v;
        mdl_clr();
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        for (int i = 0; i < 13; i++) chk_rd(6'(i * 4));
        $display("reset and unmapped test done");
        for (int it = 0; it < 24; it++) begin
            p = it % 3;
            bus_wr(6'(p * 12), rnd8());
            bus_wr(6'(p * 12 + 4), rnd8());
            bus_wr(pced_pkg::OFF_CTRL, rnd8());
            bus_wr(pced_pkg::OFF_IRQ_MSK, rnd8());
            chk_rd(6'(p * 12 + (it % 2) * 4));
            old_v = want[p];
            new_v = (it % 6 == 5) ? ~old_v : old_v ^ rnd8();  // Every pin at once now and then
            hit_v = ((new_v & ~old_v & arm_r[p]) | (old_v & ~new_v & arm_f[p])) & pmask(p);
            @(posedge core_clk);
            want[p] <= new_v;
            flg[p] = hit_v;
            if (hit_v != 8'h00) sts_m[p] = 1'b1;
            repeat (10) @(posedge core_clk);
            `CHK("pin change irq", ie_m & (|hit_v), pin_change_irq)
            `CHK("event irq", |(sts_m & msk_m), event_irq)
            chk_rd(6'(p * 12 + 8));
            bus_wr(6'(p * 12 + 8), rnd8());
            chk_rd(6'(p * 12 + 8));
            bus_wr(6'(p * 12 + 8), 8'h00);
            chk_rd(pced_pkg::OFF_IRQ_STS);
            bus_wr(pced_pkg::OFF_IRQ_STS, 8'h07);
            `CHK("pin change irq after clear", 1'b0, pin_change_irq)
            $display("edge test %0d done", it);
        end
        bus_wr(pced_pkg::OFF_C_RISE, 8'hff);
        bus_wr(pced_pkg::OFF_C_FALL, 8'hff);
        want[2] <= ~want[2];
        repeat (10) @(posedge core_clk);
        resetn <= 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        mdl_clr();
        chk_rd(pced_pkg::OFF_C_FLAG);
        chk_rd(pced_pkg::OFF_C_RISE);
        $display("mid-run reset test done");
        test_done();
    end
endmodule
